// ===== shared/nfc_cfg_pkg.sv
/*
 * constants and carriers for the front-end
 * configuration register bank.
 * assumes one 100 MHz clock, AHB-Lite access.
 */
`default_nettype none

package nfc_cfg_pkg;

    // =========================================
    // register indices; byte address = 4*index
    localparam logic [7:0] IDX_CRC_HIGH  = 8'h21;
    localparam logic [7:0] IDX_CRC_LOW   = 8'h22;
    localparam logic [7:0] IDX_DRV_OFF   = 8'h23;
    localparam logic [7:0] IDX_TX_PHASE  = 8'h25;
    localparam logic [7:0] IDX_RF_CFG    = 8'h26;

    // =========================================
    // reset values
    localparam logic [7:0] RST_CRC       = 8'hFF;
    localparam logic [7:0] RST_DRV_OFF   = 8'h88;
    localparam logic [7:0] RST_TX_PHASE  = 8'h87;
    localparam logic [7:0] RST_RF_CFG    = 8'h48;

    // =========================================
    // field positions
    localparam int UNMOD_LSB   = 4;
    localparam int MOD_LSB     = 0;
    localparam int COND_MSB    = 3;
    localparam int DEMOD_BIT   = 7;
    localparam int AMP_BIT     = 7;
    localparam int GAIN_LSB    = 4;
    localparam int SENS_LSB    = 0;

    // =========================================
    // receiver gain figures in dB
    localparam logic [5:0] GAIN_18DB = 6'h12;
    localparam logic [5:0] GAIN_23DB = 6'h17;
    localparam logic [5:0] GAIN_33DB = 6'h21;
    localparam logic [5:0] GAIN_38DB = 6'h26;
    localparam logic [5:0] GAIN_43DB = 6'h2B;
    localparam logic [5:0] GAIN_48DB = 6'h30;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // =========================================
    // carriers
    typedef struct packed {
        logic [3:0] unmod;
        logic [3:0] modul;
    } cond_s;

    typedef struct packed {
        logic       amp_en;
        logic [2:0] gain_sel;
        logic [5:0] gain_db;
        logic [3:0] sens;
    } rx_cfg_s;

endpackage

`default_nettype wire

// ===== logic/nfc_cfg_regs.sv
/*
 * configuration register bank of the card-emulation
 * front end: crc result bytes, n-driver conductance,
 * transmit bit-phase delay and receiver settings.
 * assumes an AHB-Lite master on clk and a crc engine,
 * driver control and carrier tick on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module nfc_cfg_regs
    import nfc_cfg_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // crc engine
    input  wire logic        crc_load,
    input  wire logic [15:0] crc_value,
    input  wire logic        crc_done_flag,
    output logic             crc_valid,
    // driver control
    input  wire logic        soft_power_down,
    input  wire logic        driver_off,
    input  wire cond_s       on_conductance,
    output cond_s            drive_conductance,
    // transmit timing
    input  wire logic        carrier_tick,
    input  wire logic        tx_request,
    output logic             tx_start,
    output logic             tx_waiting,
    // receiver
    output logic             demod_clock_from_field,
    output rx_cfg_s          rx_cfg
);

    // =========================================
    // bus slave
    logic       dp_write;
    logic [7:0] dp_idx;
    logic       ap_take;
    logic [7:0] ap_idx;
    logic       wr_drv;
    logic       wr_phase;
    logic       wr_rf;

    logic [7:0] crc_result_high;
    logic [7:0] crc_result_low;
    logic [7:0] driver_off_conductance;
    logic [7:0] tx_bit_phase_ctrl;
    logic [7:0] rf_receiver_config;
    logic [7:0] next_drv;
    logic [7:0] next_phase;
    logic [7:0] next_rf;
    logic [7:0] next_crc_hi;
    logic [7:0] next_crc_lo;
    logic [7:0] rd_byte;

    // no wait states: every access completes OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign ap_take = hsel && hready && htrans == HTRANS_NONSEQ;
    // upper address bits above the window alias nothing
    assign ap_idx  = (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'h00;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dp_write <= 1'b0;
            dp_idx   <= 8'h00;
        end else if (hready) begin
            dp_write <= ap_take && hwrite;
            dp_idx   <= ap_idx;
        end
    end

    assign wr_drv    = dp_write && dp_idx == IDX_DRV_OFF;
    assign wr_phase  = dp_write && dp_idx == IDX_TX_PHASE;
    assign wr_rf     = dp_write && dp_idx == IDX_RF_CFG;

    // =========================================
    // next values, shared by update and read path
    always_comb begin
        next_drv    = wr_drv   ? hwdata[7:0] : driver_off_conductance;
        next_phase  = wr_phase ? hwdata[7:0] : tx_bit_phase_ctrl;
        next_rf     = wr_rf    ? hwdata[7:0] : rf_receiver_config;
        next_crc_hi = crc_load ? crc_value[15:8] : crc_result_high;
        next_crc_lo = crc_load ? crc_value[7:0] : crc_result_low;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            driver_off_conductance <= RST_DRV_OFF;
        end else begin
            driver_off_conductance <= next_drv;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_bit_phase_ctrl <= RST_TX_PHASE;
        end else begin
            tx_bit_phase_ctrl <= next_phase;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rf_receiver_config <= RST_RF_CFG;
        end else begin
            rf_receiver_config <= next_rf;
        end
    end

    // crc result bytes follow only the engine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            crc_result_high <= RST_CRC;
            crc_result_low  <= RST_CRC;
        end else begin
            crc_result_high <= next_crc_hi;
            crc_result_low  <= next_crc_lo;
        end
    end

    // read data sampled at the address phase from next
    // values, so a read right after a write sees it
    always_comb begin
        unique case (ap_idx)
            IDX_CRC_HIGH: rd_byte = next_crc_hi;
            IDX_CRC_LOW:  rd_byte = next_crc_lo;
            IDX_DRV_OFF:  rd_byte = next_drv;
            IDX_TX_PHASE: rd_byte = next_phase;
            IDX_RF_CFG:   rd_byte = next_rf;
            default:      rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hrdata <= 32'h0;
        end else if (ap_take && !hwrite) begin
            hrdata <= {24'h0, rd_byte};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            crc_valid <= 1'b0;
        end else begin
            crc_valid <= crc_done_flag;
        end
    end

    // =========================================
    // driver conductance
    cond_s next_cond;

    always_comb begin
        if (driver_off) begin
            next_cond.unmod = driver_off_conductance[UNMOD_LSB +: 4];
            next_cond.modul = driver_off_conductance[MOD_LSB +: 4];
        end else begin
            next_cond = on_conductance;
        end
        if (soft_power_down) begin
            next_cond.unmod[COND_MSB] = 1'b1;
            next_cond.modul[COND_MSB] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drive_conductance <= '0;
        end else begin
            drive_conductance <= next_cond;
        end
    end

    // =========================================
    // receiver settings
    logic [5:0] gain_db;

    always_comb begin
        unique case (rf_receiver_config[GAIN_LSB +: 3])
            3'h0, 3'h2: gain_db = GAIN_18DB;
            3'h1, 3'h3: gain_db = GAIN_23DB;
            3'h4:       gain_db = GAIN_33DB;
            3'h5:       gain_db = GAIN_38DB;
            3'h6:       gain_db = GAIN_43DB;
            3'h7:       gain_db = GAIN_48DB;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_cfg                 <= '0;
            demod_clock_from_field <= 1'b0;
        end else begin
            rx_cfg.amp_en   <= rf_receiver_config[AMP_BIT];
            rx_cfg.gain_sel <= rf_receiver_config[GAIN_LSB +: 3];
            rx_cfg.gain_db  <= gain_db;
            rx_cfg.sens     <= rf_receiver_config[SENS_LSB +: 4];
            demod_clock_from_field <= tx_bit_phase_ctrl[DEMOD_BIT];
        end
    end

    // =========================================
    // transmit bit-phase delay in carrier cycles;
    // the same extension serves every mode, which is
    // what lines up 106k passive and card-mode bits
    typedef enum logic [0:0] {TX_IDLE, TX_WAIT} tx_state_e;
    tx_state_e  tx_state;
    logic [6:0] tx_left;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_state <= TX_IDLE;
            tx_left  <= 7'h00;
            tx_start <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            unique case (tx_state)
                TX_IDLE: begin
                    if (tx_request) begin
                        tx_left  <= tx_bit_phase_ctrl[6:0];
                        tx_state <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (tx_left == 7'h00) begin
                        tx_start <= 1'b1;
                        tx_state <= TX_IDLE;
                    end else if (carrier_tick) begin
                        tx_left <= tx_left - 7'h01;
                    end
                end
            endcase
        end
    end

    assign tx_waiting = tx_state == TX_WAIT;

    // =========================================
    // checks
    logic [7:0] tick_cnt;
    logic [6:0] tx_goal;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_cnt <= 8'h00;
            tx_goal  <= 7'h00;
        end else if (tx_state == TX_IDLE) begin
            tick_cnt <= 8'h00;
            tx_goal  <= tx_bit_phase_ctrl[6:0];
        end else if (carrier_tick && tx_left != 7'h00) begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end

    AST_CRC_HI_RESET: assert property (
        @(posedge clk) $fell(sys_rst) |-> crc_result_high == RST_CRC
    ) else $error("crc high not all ones after reset");

    AST_CRC_LO_RESET: assert property (
        @(posedge clk) $fell(sys_rst) |-> crc_result_low == RST_CRC
    ) else $error("crc low not all ones after reset");

    AST_DRV_RESET: assert property (
        @(posedge clk) $fell(sys_rst) |-> driver_off_conductance == RST_DRV_OFF
    ) else $error("conductance reset value wrong");

    AST_CRC_LOAD: assert property (
        @(posedge clk) disable iff (sys_rst)
        crc_load |=> {crc_result_high, crc_result_low} == $past(crc_value)
    ) else $error("crc bytes not loaded");

    AST_CRC_RO: assert property (
        @(posedge clk) disable iff (sys_rst)
        (dp_write && dp_idx == IDX_CRC_LOW && !crc_load) |=> $stable(crc_result_low)
    ) else $error("crc low changed by write");

    AST_PD_FORCE: assert property (
        @(posedge clk) disable iff (sys_rst)
        soft_power_down |=> drive_conductance.unmod[3] && drive_conductance.modul[3]
    ) else $error("power-down msb not forced");

    AST_OFF_SELECT: assert property (
        @(posedge clk) disable iff (sys_rst)
        (driver_off && !soft_power_down && !sys_rst) |=>
        drive_conductance == $past(driver_off_conductance)
    ) else $error("off fields not applied");

    AST_ON_SELECT: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!driver_off && !soft_power_down) |=> drive_conductance == $past(on_conductance)
    ) else $error("on fields not applied");

    AST_DEMOD_CLK: assert property (
        @(posedge clk) disable iff (sys_rst)
        !sys_rst && tx_bit_phase_ctrl[7] |=> demod_clock_from_field
    ) else $error("demod clock source wrong");

    AST_TX_DELAY: assert property (
        @(posedge clk) disable iff (sys_rst)
        tx_start |-> tick_cnt == {1'b0, tx_goal}
    ) else $error("transmit delay count wrong");

    AST_TX_ZERO: assert property (
        @(posedge clk) disable iff (sys_rst)
        (tx_state == TX_IDLE && tx_request && tx_bit_phase_ctrl[6:0] == 7'h00)
        |=> ##1 tx_start
    ) else $error("zero delay start late");

    AST_AMP: assert property (
        @(posedge clk) disable iff (sys_rst)
        rf_receiver_config[7] |=> rx_cfg.amp_en
    ) else $error("level amp not enabled");

    AST_GAIN_LOW: assert property (
        @(posedge clk) disable iff (sys_rst)
        rf_receiver_config[6] == 1'b0 && rf_receiver_config[4] == 1'b0 |=> rx_cfg.gain_db == GAIN_18DB
    ) else $error("gain code 0/2 wrong");

    AST_GAIN_TOP: assert property (
        @(posedge clk) disable iff (sys_rst)
        rf_receiver_config[6:4] == 3'h7 |=> rx_cfg.gain_db == GAIN_48DB
    ) else $error("gain code 7 wrong");

    AST_SENS: assert property (
        @(posedge clk) disable iff (sys_rst)
        !sys_rst |-> ##1 rx_cfg.sens == $past(rf_receiver_config[3:0])
    ) else $error("sensitivity not passed");

    COV_DRV_WRITE: cover property (@(posedge clk) disable iff (sys_rst) wr_drv);
    COV_CRC_LOAD: cover property (@(posedge clk) disable iff (sys_rst) crc_load ##1 crc_valid);
    COV_TX_DELAY: cover property (@(posedge clk) disable iff (sys_rst)
        tx_request ##[1:200] tx_start);
    COV_PD_OFF: cover property (@(posedge clk) disable iff (sys_rst)
        soft_power_down && driver_off);

endmodule

`default_nettype wire

// ===== bench/tb_nfc_cfg_regs.sv
/*
 * self-checking bench for the front-end configuration register bank.
 * assumes the design answers with zero wait states and that the bench alone
 * drives every input except hready, which loops back from hreadyout: bus, crc engine, driver control and carrier ticks.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_nfc_cfg_regs
    import nfc_cfg_pkg::*;
;
    // =========================================
    // signals
    typedef struct {int kind; logic [31:0] val;} note_s;
    logic        clk = 1'b0;
    logic        sys_rst, hsel, hwrite, hreadyout, hresp, crc_load, crc_done_flag, crc_valid;
    logic        soft_power_down, driver_off, carrier_tick, tx_request, tx_start, tx_waiting;
    logic        demod_clock_from_field, rd_phase, port_due;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] crc_value;
    cond_s       on_conductance, drive_conductance;
    rx_cfg_s     rx_cfg;
    logic [7:0]  drv_off_m, phase_m, rf_m, crc_hi_m, crc_lo_m;
    logic [31:0] rq[$];
    note_s       pq[$];
    note_s       mn;
    int          tq[$];
    int          cyc, tx_seen, num_errors, samples_checked;

    always #5 clk = ~clk;

    nfc_cfg_regs nfc_cfg_regs_inst (
        .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .crc_load(crc_load), .crc_value(crc_value), .crc_done_flag(crc_done_flag),
        .crc_valid(crc_valid), .soft_power_down(soft_power_down), .driver_off(driver_off),
        .on_conductance(on_conductance), .drive_conductance(drive_conductance),
        .carrier_tick(carrier_tick), .tx_request(tx_request), .tx_start(tx_start),
        .tx_waiting(tx_waiting), .demod_clock_from_field(demod_clock_from_field), .rx_cfg(rx_cfg)
    );

    // =========================================
    // reporting
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_data(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_port(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // =========================================
    // monitor: pops every queued note, oldest first, whenever a result is due
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rd_phase === 1'b1) cmp_data("hrdata", rq.pop_front(), hrdata);
        if (rd_phase === 1'b1) cmp_data("hresp", 32'h0, {31'h0, hresp});
        if (tq.size() > 0 && cyc == tq[0] - 1) cmp_port("tx_waiting", 32'h1, {31'h0, tx_waiting});
        while (port_due === 1'b1 && pq.size() > 0) begin
            mn = pq.pop_front();
            case (mn.kind)
                1: cmp_port("drive_conductance", mn.val, {24'h0, drive_conductance});
                2: cmp_port("rx_cfg", mn.val, {18'h0, rx_cfg});
                3: cmp_port("demod_clock_from_field", mn.val, {31'h0, demod_clock_from_field});
                default: cmp_port("crc_valid", mn.val, {31'h0, crc_valid});
            endcase
        end
        if (tx_start === 1'b1) begin
            if (tq.size() == 0) cmp_port("tx_start extra", 32'h0, 32'h1);
            else cmp_port("tx_start cycle", tq.pop_front(), cyc);
            cmp_port("tx_waiting", 32'h0, {31'h0, tx_waiting});
            tx_seen <= tx_seen + 1;
        end
    end

    // =========================================
    // ahb-lite master
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            close_out();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] v);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, v};
        if (!wr) rq.push_back({24'h0, v});
        rd_phase <= !wr;
        wait_ready();
        rd_phase <= 1'b0;
    endtask

    function automatic logic [5:0] gdb(input logic [2:0] c);
        case (c)
            3'h0, 3'h2: return GAIN_18DB;
            3'h1, 3'h3: return GAIN_23DB;
            3'h4: return GAIN_33DB;
            3'h5: return GAIN_38DB;
            3'h6: return GAIN_43DB;
            default: return GAIN_48DB;
        endcase
    endfunction

    // outputs are registered copies; three edges leave ample margin after a write
    task automatic chk_ports();
        cond_s src;
        repeat (3) @(posedge clk);
        src = driver_off ? cond_s'(drv_off_m) : on_conductance;
        if (soft_power_down) begin
            src.unmod[3] = 1'b1;
            src.modul[3] = 1'b1;
        end
        pq.push_back('{1, {24'h0, src}});
        pq.push_back('{2, {18'h0, rf_m[7], rf_m[6:4], gdb(rf_m[6:4]), rf_m[3:0]}});
        pq.push_back('{3, {31'h0, phase_m[7]}});
        pq.push_back('{4, {31'h0, crc_done_flag}});
        port_due <= 1'b1;
        @(posedge clk);
        port_due <= 1'b0;
    endtask

    // ticks come on every other cycle so the count must wait through gaps
    task automatic tx_run(input int n);
        int e0, k, s0;
        s0 = tx_seen;
        tx_request <= 1'b1;
        @(posedge clk);
        e0 = cyc;
        tx_request <= 1'b0;
        tq.push_back(e0 + ((n == 0) ? 2 : 2 * n + 1));
        for (k = 0; k < n; k++) begin
            carrier_tick <= 1'b1;
            @(posedge clk);
            carrier_tick <= 1'b0;
            tx_request   <= (k == 0 && n > 1);
            @(posedge clk);
            tx_request   <= 1'b0;
        end
        k = 0;
        while (tx_seen != s0 + 1 && k < 300) begin
            @(posedge clk);
            k++;
        end
        if (tx_seen != s0 + 1) begin
            num_errors++;
            close_out();
        end
    endtask

    // =========================================
    // main sequence
    initial begin
        logic [31:0] r;
        int i;
        int ns[5];
        void'($urandom(32'h893e4932));
        {sys_rst, hsel, hwrite, htrans, haddr, hwdata} <= {1'b1, 1'b0, 1'b0, 2'h0, 64'h0};
        {crc_load, crc_value, crc_done_flag, soft_power_down, driver_off} <= {1'b0, 16'h0, 3'b001};
        {on_conductance, carrier_tick, tx_request, rd_phase, port_due} <= {8'h0, 4'h0};
        cyc = 0;
        tx_seen = 0;
        num_errors = 0;
        samples_checked = 0;
        {drv_off_m, phase_m, rf_m} = {RST_DRV_OFF, RST_TX_PHASE, RST_RF_CFG};
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b0, IDX_CRC_HIGH, RST_CRC);
        bus(1'b0, IDX_CRC_LOW, RST_CRC);
        bus(1'b0, IDX_DRV_OFF, RST_DRV_OFF);
        bus(1'b0, IDX_TX_PHASE, RST_TX_PHASE);
        bus(1'b0, IDX_RF_CFG, RST_RF_CFG);
        bus(1'b0, 8'h24, 8'h00);
        chk_ports();
        $display("test reset_values done");
        for (i = 0; i < 4; i++) begin
            r = $urandom;
            {drv_off_m, rf_m} = r[15:0];
            bus(1'b1, IDX_DRV_OFF, drv_off_m);
            bus(1'b1, IDX_RF_CFG, rf_m);
            bus(1'b1, IDX_CRC_HIGH, r[23:16]);
            bus(1'b1, IDX_CRC_LOW, r[31:24]);
            bus(1'b1, 8'h30, r[7:0]);
            bus(1'b0, IDX_DRV_OFF, drv_off_m);
            bus(1'b0, IDX_RF_CFG, rf_m);
            bus(1'b0, IDX_CRC_HIGH, RST_CRC);
            bus(1'b0, IDX_CRC_LOW, RST_CRC);
            bus(1'b0, 8'h30, 8'h00);
        end
        drv_off_m = 8'h3F;
        bus(1'b1, IDX_DRV_OFF, drv_off_m);
        bus(1'b0, IDX_DRV_OFF, drv_off_m);
        $display("test read_write done");
        for (i = 0; i < 8; i++) begin
            r = $urandom;
            rf_m = {r[7], i[2:0], r[3:0]};
            bus(1'b1, IDX_RF_CFG, rf_m);
            chk_ports();
        end
        $display("test gain_table done");
        for (i = 0; i < 8; i++) begin
            r = $urandom;
            drv_off_m = r[7:0];
            bus(1'b1, IDX_DRV_OFF, drv_off_m);
            driver_off      <= i[0];
            soft_power_down <= i[1];
            on_conductance  <= r[15:8];
            chk_ports();
        end
        $display("test conductance done");
        r = $urandom;
        {crc_hi_m, crc_lo_m} = r[15:0];
        crc_value <= r[15:0];
        crc_load  <= 1'b1;
        @(posedge clk);
        crc_load      <= 1'b0;
        crc_done_flag <= 1'b1;
        bus(1'b0, IDX_CRC_HIGH, crc_hi_m);
        bus(1'b0, IDX_CRC_LOW, crc_lo_m);
        bus(1'b1, IDX_CRC_HIGH, ~crc_hi_m);
        bus(1'b0, IDX_CRC_HIGH, crc_hi_m);
        chk_ports();
        $display("test crc done");
        phase_m = 8'h84;
        bus(1'b1, IDX_TX_PHASE, phase_m);
        chk_ports();
        tx_run(4);
        r = $urandom;
        ns = '{0, 1, 2, 5, 3 + int'(r[1:0])};
        for (i = 0; i < 5; i++) begin
            r = $urandom;
            phase_m = {r[0], ns[i][6:0]};
            bus(1'b1, IDX_TX_PHASE, phase_m);
            chk_ports();
            tx_run(ns[i]);
        end
        $display("test tx_delay done");
        close_out();
    end
endmodule

`default_nettype wire
